//--- bench/lpb_flash_model.sv
// external memory or peripheral on the chip selects of the cycle engine
// assumes registered selects from the engine; sixteen words, addr[3:0]
`timescale 1ns/1ps
module lpb_flash_model (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  cs_n_i,
  input  wire logic        rw_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [15:0] ack_after_i,
  output logic      [31:0] rdata_o,
  output logic             ack_n_o
);
  logic [31:0] mem_r [0:15];
  logic [31:0] last_r;
  logic        hold_r;
  logic [15:0] cnt_r;
  logic        sel;

  assign sel = (cs_n_i != 8'hFF);
  // released bus keeps the last read word two cycles, then toggles so a later capture cannot match by luck
  assign rdata_o = (sel && rw_i) ? mem_r[addr_i[3:0]] : last_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_r <= 32'h0;
      hold_r <= 1'b0;
    end else if (sel && rw_i) begin
      last_r <= mem_r[addr_i[3:0]];
      hold_r <= 1'b1;
    end else if (hold_r) begin
      hold_r <= 1'b0;
    end else begin
      last_r <= ~last_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sel && !rw_i) begin
      mem_r[addr_i[3:0]] <= wdata_i;
    end
  end

  // zero ack_after_i means never acknowledge
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r   <= 16'h0000;
      ack_n_o <= 1'b1;
    end else if (!sel) begin
      cnt_r   <= 16'h0000;
      ack_n_o <= 1'b1;
    end else begin
      cnt_r   <= cnt_r + 16'h0001;
      ack_n_o <= !(ack_after_i != 0 && cnt_r + 1 >= ack_after_i);
    end
  end
endmodule : lpb_flash_model

//--- bench/testbench.sv
// self-checking bench for the non-multiplexed local bus cycle engine
// assumes default parameters; tick every core clock
`timescale 1ns/1ps
module testbench;
  import lpb_pkg::*;
  logic        core_clk_i, reset_i, req_valid_i, req_ready, req_write_i;
  logic [2:0]  req_cs_i, req_size_i, cfg_sel_i, tbc;
  logic [23:0] req_addr_i, addr;
  logic [7:0]  req_addr_hi_i, cfg_pw, cfg_xw, cs_n, addr_hi;
  logic [31:0] req_wdata_i, rdata, dout, din;
  logic        rsp_valid, rsp_error, rsp_early, cfg_we_i, cfg_enable_i;
  logic [3:0]  cfg_turn;
  lpb_mode_t   cfg_mode, cur_mode;
  logic        busy, hi_oe_n, rw, oe_n, dout_oe_n, ack_n, start_n;
  logic [15:0] ack_after;
  logic [31:0] prev_dout;
  logic [23:0] prev_addr;
  logic [7:0]  last_cs;
  logic        prev_act, prev_rw;
  int errors, n_tests, lo_w, last_w, start_cnt, act_cnt, since_rd, cur_turn;

  lpb_nonmux dut_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready), .req_cs_i(req_cs_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_addr_hi_i(req_addr_hi_i),
    .req_wdata_i(req_wdata_i), .req_size_i(req_size_i),
    .rsp_valid_o(rsp_valid), .rsp_error_o(rsp_error),
    .rsp_early_ack_o(rsp_early), .rsp_rdata_o(rdata), .cfg_we_i(cfg_we_i),
    .cfg_sel_i(cfg_sel_i), .cfg_enable_i(cfg_enable_i),
    .cfg_primary_wait_i(cfg_pw), .cfg_extra_wait_i(cfg_xw),
    .cfg_turnaround_i(cfg_turn), .cfg_mode_i(cfg_mode), .busy_o(busy),
    .lb_cs_n_o(cs_n), .lb_addr_o(addr), .lb_addr_hi_o(addr_hi),
    .lb_addr_hi_oe_n_o(hi_oe_n), .lb_rw_o(rw), .lb_oe_n_o(oe_n),
    .lb_data_o(dout), .lb_data_oe_n_o(dout_oe_n), .lb_data_i(din),
    .lb_ack_n_i(ack_n), .transfer_start_strobe_n_o(start_n),
    .transfer_byte_count_o(tbc));

  lpb_flash_model mem_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .rw_i(rw),
    .addr_i(addr), .wdata_i(dout), .ack_after_i(ack_after),
    .rdata_o(din), .ack_n_o(ack_n));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic give_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  // pin-level watcher; samples registered outputs before each edge
  always @(posedge core_clk_i) begin
    if (!reset_i) begin
      if (cs_n != 8'hFF) begin
        act_cnt++;
        last_cs = cs_n;
        if (!prev_act) begin
          lo_w = 0;
          chk(rw === prev_rw && addr === prev_addr, "setup");
          chk(since_rd > cur_turn, "gap after read");
        end
        lo_w++;
        chk(busy === 1'b1, "busy during select");
        chk(oe_n === !rw && (rw || dout_oe_n === 1'b0), "enables");
        chk(hi_oe_n === (cur_mode == LPB_MODE_PLAIN), "upper pins");
      end else begin
        if (prev_act) begin
          last_w = lo_w;
          chk(rw === prev_rw && addr === prev_addr, "hold");
          chk(hi_oe_n === 1'b1, "upper pins released");
          if (!prev_rw) chk(dout === prev_dout && !dout_oe_n, "wr hold");
          since_rd = prev_rw ? 0 : 1000;
        end
        since_rd++;
        if (dout_oe_n === 1'b0)
          chk(since_rd > cur_turn + 1, "bus turn");
      end
      if (start_n === 1'b0) start_cnt++;
    end
    prev_act = (cs_n != 8'hFF);
    prev_rw = rw;
    prev_addr = addr;
    prev_dout = dout;
  end

  task automatic set_cs(input int s, input bit en, input logic [15:0] w,
                        input logic [3:0] tn, input lpb_mode_t m);
    cfg_sel_i = s[2:0];
    cfg_enable_i = en;
    {cfg_pw, cfg_xw} = w;
    cfg_turn = tn;
    cfg_mode = m;
    cfg_we_i = 1'b1;
    @(posedge core_clk_i);
    #1 cfg_we_i = 1'b0;
  endtask : set_cs

  task automatic xfer(input int s, input bit wr, input logic [31:0] d);
    int n;
    req_cs_i = s[2:0];
    req_write_i = wr;
    req_addr_i = {s[3:0], 16'h0000, s[3:0]};
    req_addr_hi_i = 8'hC0 | 8'(s);
    req_wdata_i = d;
    req_size_i = s[2:0];
    req_valid_i = 1'b1;
    start_cnt = 0;
    n = 0;
    #8;
    while (req_ready !== 1'b1 && n < 400) begin
      @(posedge core_clk_i);
      #9 n++;
    end
    @(posedge core_clk_i);
    #1 req_valid_i = 1'b0;
    while (rsp_valid !== 1'b1 && n < 800) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    if (n >= 400) chk(1'b0, "no answer");
    @(posedge core_clk_i);
    #1;
  endtask : xfer

  task automatic run(input int s, input bit wr, input logic [31:0] d,
                     input int w, input bit early);
    xfer(s, wr, d);
    chk(rsp_error === 1'b0 && last_cs === ~(8'h01 << s), "select");
    chk(rsp_early === early, "early flag");
    if (!early) chk(last_w == 2 + w, "select width");
    else chk(last_w < 2 + w && last_w >= 2, "ack width");
    chk(start_cnt == int'(cur_mode != LPB_MODE_PLAIN), "start strobe");
    if (cur_mode != LPB_MODE_PLAIN)
      chk(addr_hi === (8'hC0 | 8'(s)), "upper address");
    if (cur_mode == LPB_MODE_GRAPHICS) chk(tbc === s[2:0], "size");
    if (!wr) chk(rdata === d, "read data");
  endtask : run

  initial begin
    reset_i = 1'b1;
    {req_valid_i, req_write_i, cfg_we_i, cfg_enable_i} = 4'h0;
    {req_cs_i, req_size_i, cfg_sel_i, cfg_turn} = 13'h0000;
    {req_addr_i, req_addr_hi_i, req_wdata_i} = 64'h0;
    {cfg_pw, cfg_xw, ack_after} = 32'h0;
    cfg_mode = LPB_MODE_PLAIN;
    cur_mode = LPB_MODE_PLAIN;
    {errors, n_tests, act_cnt, cur_turn, last_w} = '0;
    since_rd = 1000;
    repeat (3) @(posedge core_clk_i);
    #1 reset_i = 1'b0;
    chk(cs_n === 8'hFF && oe_n && start_n && rw && dout_oe_n && hi_oe_n,
        "rst");
    for (int s = 0; s < 8; s++) begin
      cur_mode = lpb_mode_t'(2'(s % 3));
      set_cs(s, 1'b1, 16'(s), 4'h0, cur_mode);
      run(s, 1'b1, 32'hA5C3_0000 | s, s, 1'b0);
      run(s, 1'b0, 32'hA5C3_0000 | s, s, 1'b0);
    end
    cur_mode = LPB_MODE_PLAIN;
    set_cs(3, 1'b1, 16'h0102, 4'h0, LPB_MODE_PLAIN);
    run(3, 1'b1, 32'h5A5A_0F0F, 258, 1'b0);
    chk(tbc === 3'h5, "size kept outside graphics mode");
    set_cs(2, 1'b1, 16'h000A, 4'h0, LPB_MODE_PLAIN);
    ack_after = 16'h0001;
    run(2, 1'b0, 32'hA5C3_0002, 10, 1'b1);
    ack_after = 16'h0000;
    set_cs(5, 1'b0, 16'h0000, 4'h0, LPB_MODE_PLAIN);
    act_cnt = 0;
    xfer(5, 1'b1, 32'h1234_5678);
    chk(rsp_error === 1'b1 && act_cnt == 0, "disabled select");
    set_cs(6, 1'b1, 16'h0000, 4'h5, LPB_MODE_PLAIN);
    cur_turn = 5;
    run(6, 1'b0, 32'hA5C3_0006, 0, 1'b0);
    // select 7 keeps its wide flash setup from the loop
    cur_mode = LPB_MODE_WIDE_FLASH;
    run(7, 1'b1, 32'h0BAD_F00D, 7, 1'b0);
    cur_mode = LPB_MODE_PLAIN;
    cur_turn = 0;
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    give_verdict();
  end
endmodule : testbench

//--- pkg/lpb_map.svh
// constants for the non-multiplexed local bus cycle engine
// assumes inclusion by the package and the engine; definitions only
`ifndef LPB_MAP_SVH
`define LPB_MAP_SVH

`define LPB_MAX_CS          8
`define LPB_CORE_CLK_MHZ    50
`define LPB_BUS_MAX_MHZ     66
`define LPB_REF_DIV_MIN \
  ((`LPB_CORE_CLK_MHZ + `LPB_BUS_MAX_MHZ - 1) / `LPB_BUS_MAX_MHZ)
`define LPB_CS_BASE_TICKS   2
`define LPB_PRIMARY_WAIT_LSB 8
`define LPB_EXTRA_WAIT_LSB  0
`define LPB_WAIT_FIELD_W    8
`define LPB_WAIT_W          16
`define LPB_TURN_W          4
`define LPB_SETUP_TICKS     1
`define LPB_HOLD_TICKS      1
`define LPB_CS_N_RESET      8'hFF
`define LPB_WAIT_RESET      16'h0000
`define LPB_TURN_RESET      4'h0

`endif

//--- pkg/lpb_pkg.sv
// types shared by the local bus cycle engine and its helpers
// assumes the constants header is found by bare name
`include "lpb_map.svh"
package lpb_pkg;
  typedef enum logic [1:0] {
    LPB_MODE_PLAIN,
    LPB_MODE_WIDE_FLASH,
    LPB_MODE_GRAPHICS
  } lpb_mode_t;

  typedef enum logic [2:0] {
    LPB_ST_IDLE,
    LPB_ST_SETUP,
    LPB_ST_ACTIVE,
    LPB_ST_HOLD,
    LPB_ST_TURN
  } lpb_state_t;
endpackage : lpb_pkg

//--- rtl/lpb_cs_table.sv
// per chip-select configuration store, written through plain ports
// assumes the engine reads the entry of the select it is about to use
`timescale 1ns/1ps
`include "lpb_map.svh"
module lpb_cs_table
  import lpb_pkg::*;
#(
  parameter int NUM_CS = `LPB_MAX_CS,
  parameter int IDX_W  = 3
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    cfg_we_i,
  input  wire logic [IDX_W-1:0]        cfg_sel_i,
  input  wire logic                    cfg_enable_i,
  input  wire logic [`LPB_WAIT_FIELD_W-1:0] cfg_primary_wait_i,
  input  wire logic [`LPB_WAIT_FIELD_W-1:0] cfg_extra_wait_i,
  input  wire logic [`LPB_TURN_W-1:0]  cfg_turnaround_i,
  input  wire lpb_pkg::lpb_mode_t      cfg_mode_i,
  input  wire logic [IDX_W-1:0]        rd_sel_i,
  output logic                         rd_enable_o,
  output logic [`LPB_WAIT_W-1:0]       rd_wait_o,
  output logic [`LPB_TURN_W-1:0]       rd_turn_o,
  output lpb_pkg::lpb_mode_t           rd_mode_o
);
  logic                      en_r   [NUM_CS];
  logic [`LPB_WAIT_W-1:0]    wait_r [NUM_CS];
  logic [`LPB_TURN_W-1:0]    turn_r [NUM_CS];
  lpb_mode_t                 mode_r [NUM_CS];

  // each select configured on its own
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CS; i++) begin
        en_r[i]   <= 1'b0;
        wait_r[i] <= `LPB_WAIT_RESET;
        turn_r[i] <= `LPB_TURN_RESET;
        mode_r[i] <= LPB_MODE_PLAIN;
      end
    end else if (cfg_we_i && (int'(cfg_sel_i) < NUM_CS)) begin
      en_r[cfg_sel_i]   <= cfg_enable_i;
      wait_r[cfg_sel_i] <= {cfg_primary_wait_i, cfg_extra_wait_i};
      turn_r[cfg_sel_i] <= cfg_turnaround_i;
      mode_r[cfg_sel_i] <= cfg_mode_i;
    end
  end

  // out-of-range select reads as a disabled entry
  always_comb begin
    rd_enable_o = 1'b0;
    rd_wait_o   = `LPB_WAIT_RESET;
    rd_turn_o   = `LPB_TURN_RESET;
    rd_mode_o   = LPB_MODE_PLAIN;
    if (int'(rd_sel_i) < NUM_CS) begin
      rd_enable_o = en_r[rd_sel_i];
      rd_wait_o   = wait_r[rd_sel_i];
      rd_turn_o   = turn_r[rd_sel_i];
      rd_mode_o   = mode_r[rd_sel_i];
    end
  end
endmodule : lpb_cs_table

//--- rtl/lpb_nonmux.sv
// non-multiplexed local bus cycle engine with chip selects and assertions
// assumes external parts obey the acknowledge window; one core clock
`timescale 1ns/1ps
`include "lpb_map.svh"
module lpb_nonmux
  import lpb_pkg::*;
#(
  parameter int NUM_CS  = `LPB_MAX_CS,
  parameter int ADDR_W  = 24,
  parameter int HI_W    = 8,
  parameter int DATA_W  = 32,
  parameter int SIZE_W  = 3,
  parameter int REF_DIV = 1
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   req_valid_i,
  output logic                        req_ready_o,
  input  wire logic [2:0]             req_cs_i,
  input  wire logic                   req_write_i,
  input  wire logic [ADDR_W-1:0]      req_addr_i,
  input  wire logic [HI_W-1:0]        req_addr_hi_i,
  input  wire logic [DATA_W-1:0]      req_wdata_i,
  input  wire logic [SIZE_W-1:0]      req_size_i,
  output logic                        rsp_valid_o,
  output logic                        rsp_error_o,
  output logic                        rsp_early_ack_o,
  output logic [DATA_W-1:0]           rsp_rdata_o,
  input  wire logic                   cfg_we_i,
  input  wire logic [2:0]             cfg_sel_i,
  input  wire logic                   cfg_enable_i,
  input  wire logic [7:0]             cfg_primary_wait_i,
  input  wire logic [7:0]             cfg_extra_wait_i,
  input  wire logic [`LPB_TURN_W-1:0] cfg_turnaround_i,
  input  wire lpb_pkg::lpb_mode_t     cfg_mode_i,
  output logic                        busy_o,
  output logic [`LPB_MAX_CS-1:0]      lb_cs_n_o,
  output logic [ADDR_W-1:0]           lb_addr_o,
  output logic [HI_W-1:0]             lb_addr_hi_o,
  output logic                        lb_addr_hi_oe_n_o,
  output logic                        lb_rw_o,
  output logic                        lb_oe_n_o,
  output logic [DATA_W-1:0]           lb_data_o,
  output logic                        lb_data_oe_n_o,
  input  wire logic [DATA_W-1:0]      lb_data_i,
  input  wire logic                   lb_ack_n_i,
  output logic                        transfer_start_strobe_n_o,
  output logic [SIZE_W-1:0]           transfer_byte_count_o
);
  localparam int CNT_W = `LPB_WAIT_W + 1;

  lpb_state_t                state_r;
  logic                      tick;
  logic [CNT_W-1:0]          cnt_r;
  logic [2:0]                sel_r;
  logic                      write_r;
  logic [`LPB_WAIT_W-1:0]    wait_cycles_r;
  logic [`LPB_TURN_W-1:0]    turnaround_cycles_r;
  lpb_mode_t                 mode_r;
  logic                      cfg_en;
  logic [`LPB_WAIT_W-1:0]    cfg_wait;
  logic [`LPB_TURN_W-1:0]    cfg_turn;
  lpb_mode_t                 cfg_mode;
  logic                      accept;
  logic                      ack_seen;
  logic                      cs_end;

  // a faster reference would break the external timing
  initial begin
    if (REF_DIV < `LPB_REF_DIV_MIN) $error("lpb_nonmux: bus above 66 MHz");
    if (NUM_CS < 1 || NUM_CS > `LPB_MAX_CS) $error("lpb_nonmux: NUM_CS");
    if (ADDR_W < 1 || HI_W < 1 || SIZE_W < 1) $error("lpb_nonmux: widths");
    if (DATA_W != 8 && DATA_W != 16 && DATA_W != 32)
      $error("lpb_nonmux: DATA_W must be 8, 16 or 32");
  end

  function automatic logic wide_mode(input lpb_mode_t m);
    return (m == LPB_MODE_WIDE_FLASH) || (m == LPB_MODE_GRAPHICS);
  endfunction : wide_mode

  lpb_tick_div #(.DIV(REF_DIV)) u_div (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .tick_o     (tick)
  );

  lpb_cs_table #(.NUM_CS(NUM_CS), .IDX_W(3)) u_table (
    .core_clk_i         (core_clk_i),
    .reset_i            (reset_i),
    .cfg_we_i           (cfg_we_i),
    .cfg_sel_i          (cfg_sel_i),
    .cfg_enable_i       (cfg_enable_i),
    .cfg_primary_wait_i (cfg_primary_wait_i),
    .cfg_extra_wait_i   (cfg_extra_wait_i),
    .cfg_turnaround_i   (cfg_turnaround_i),
    .cfg_mode_i         (cfg_mode_i),
    .rd_sel_i           (req_cs_i),
    .rd_enable_o        (cfg_en),
    .rd_wait_o          (cfg_wait),
    .rd_turn_o          (cfg_turn),
    .rd_mode_o          (cfg_mode)
  );

  // requests only on a tick so setup spans a full reference period
  assign req_ready_o = (state_r == LPB_ST_IDLE) && tick;
  assign accept      = req_valid_i && req_ready_o;
  assign busy_o      = (state_r != LPB_ST_IDLE);
  // acknowledge ignored in the first select tick
  assign ack_seen    = !lb_ack_n_i && (cnt_r != '0);
  assign cs_end      = (state_r == LPB_ST_ACTIVE) && tick &&
                       ((cnt_r == (CNT_W'(wait_cycles_r) + 1'b1)) ||
                        ack_seen);

  // sequencing and cycle counter
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= LPB_ST_IDLE;
      cnt_r   <= '0;
    end else if (tick) begin
      case (state_r)
        LPB_ST_IDLE: begin
          if (accept && cfg_en) begin
            state_r <= LPB_ST_SETUP;
          end
        end
        LPB_ST_SETUP: begin
          state_r <= LPB_ST_ACTIVE;
          cnt_r   <= '0;
        end
        LPB_ST_ACTIVE: begin
          if (cs_end) begin
            state_r <= LPB_ST_HOLD;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        LPB_ST_HOLD: begin
          cnt_r <= CNT_W'(1);
          if (!write_r && turnaround_cycles_r != '0) begin
            state_r <= LPB_ST_TURN;
          end else begin
            state_r <= LPB_ST_IDLE;
          end
        end
        LPB_ST_TURN: begin
          if (cnt_r >= CNT_W'(turnaround_cycles_r)) begin
            state_r <= LPB_ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= LPB_ST_IDLE;
      endcase
    end
  end

  // latched request and its select's configuration
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_r               <= 3'h0;
      write_r             <= 1'b0;
      wait_cycles_r       <= `LPB_WAIT_RESET;
      turnaround_cycles_r <= `LPB_TURN_RESET;
      mode_r              <= LPB_MODE_PLAIN;
    end else if (accept && cfg_en) begin
      sel_r               <= req_cs_i;
      write_r             <= req_write_i;
      wait_cycles_r       <= cfg_wait;
      turnaround_cycles_r <= cfg_turn;
      mode_r              <= cfg_mode;
    end
  end

  // address and direction presented one tick ahead, byte count too in graphics mode only
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lb_addr_o             <= '0;
      lb_addr_hi_o          <= '0;
      lb_rw_o               <= 1'b1;
      transfer_byte_count_o <= '0;
    end else if (accept && cfg_en) begin
      lb_addr_o    <= req_addr_i;
      lb_addr_hi_o <= req_addr_hi_i;
      lb_rw_o      <= !req_write_i;
      if (cfg_mode == LPB_MODE_GRAPHICS) begin
        transfer_byte_count_o <= req_size_i;
      end
    end
  end

  // strobes: select, output enable, start strobe, upper pins
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lb_cs_n_o         <= `LPB_CS_N_RESET;
      lb_oe_n_o         <= 1'b1;
      transfer_start_strobe_n_o <= 1'b1;
      lb_addr_hi_oe_n_o <= 1'b1;
    end else if (tick) begin
      if (accept && cfg_en) begin
        transfer_start_strobe_n_o <= !wide_mode(cfg_mode);
        lb_addr_hi_oe_n_o <= !wide_mode(cfg_mode);
      end else if (state_r == LPB_ST_SETUP) begin
        transfer_start_strobe_n_o <= 1'b1;
        lb_cs_n_o[sel_r] <= 1'b0;
        lb_oe_n_o        <= write_r;
      end else if (cs_end) begin
        lb_cs_n_o         <= `LPB_CS_N_RESET;
        lb_oe_n_o         <= 1'b1;
        lb_addr_hi_oe_n_o <= 1'b1;
      end
    end
  end

  // write data driven setup through hold, never on reads
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lb_data_o      <= '0;
      lb_data_oe_n_o <= 1'b1;
    end else if (tick) begin
      if (accept && cfg_en && req_write_i) begin
        lb_data_o      <= req_wdata_i;
        lb_data_oe_n_o <= 1'b0;
      end else if (state_r == LPB_ST_HOLD) begin
        lb_data_oe_n_o <= 1'b1;
      end
    end
  end

  // answer: read data caught as the select ends
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_valid_o     <= 1'b0;
      rsp_error_o     <= 1'b0;
      rsp_early_ack_o <= 1'b0;
      rsp_rdata_o     <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (accept && !cfg_en) begin
        rsp_valid_o     <= 1'b1;
        rsp_error_o     <= 1'b1;
        rsp_early_ack_o <= 1'b0;
      end else if (cs_end) begin
        rsp_valid_o     <= 1'b1;
        rsp_error_o     <= 1'b0;
        rsp_early_ack_o <= ack_seen &&
                           (cnt_r != (CNT_W'(wait_cycles_r) + 1'b1));
        if (!write_r) begin
          rsp_rdata_o <= lb_data_i;
        end
      end
    end
  end

  // helper counters that only the checks below read
  logic             cs_on;
  logic [CNT_W:0]   cs_ticks_r;
  logic [CNT_W:0]   gap_r;
  logic             after_read_r;
  // the next acceptance reloads turnaround_cycles_r, so keep the read's
  logic [`LPB_TURN_W-1:0] turn_seen_r;

  assign cs_on = !(&lb_cs_n_o);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_ticks_r <= '0;
    end else if (!cs_on) begin
      cs_ticks_r <= '0;
    end else if (tick) begin
      cs_ticks_r <= cs_ticks_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_r        <= '0;
      after_read_r <= 1'b0;
      turn_seen_r  <= `LPB_TURN_RESET;
    end else if (cs_on) begin
      gap_r        <= '0;
      after_read_r <= lb_rw_o;
      turn_seen_r  <= turnaround_cycles_r;
    end else if (tick && gap_r != '1) begin
      gap_r <= gap_r + 1'b1;
    end
  end

  property p_cs_width;
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(&lb_cs_n_o) && !rsp_early_ack_o |->
      cs_ticks_r == (CNT_W + 1)'(wait_cycles_r) + `LPB_CS_BASE_TICKS;
  endproperty
  a_cs_width: assert property (p_cs_width)
    else $error("select width differs from two plus wait ticks");

  property p_ack_ends;
    @(posedge core_clk_i) disable iff (reset_i)
    (state_r == LPB_ST_ACTIVE) && tick && cnt_r != '0 && !lb_ack_n_i
      |=> (&lb_cs_n_o) && (state_r == LPB_ST_HOLD);
  endproperty
  a_ack_ends: assert property (p_ack_ends)
    else $error("acknowledge did not end the select");

  property p_one_cs;
    @(posedge core_clk_i) disable iff (reset_i)
    $countones(~lb_cs_n_o) <= 1;
  endproperty
  a_one_cs: assert property (p_one_cs)
    else $error("more than one select active");

  property p_setup;
    @(posedge core_clk_i) disable iff (reset_i)
    $fell(&lb_cs_n_o) |-> $stable(lb_addr_o) && $stable(lb_rw_o) &&
      (lb_rw_o || $stable(lb_data_o));
  endproperty
  a_setup: assert property (p_setup)
    else $error("address, direction or data changed as select fell");

  property p_hold;
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(&lb_cs_n_o) |-> $stable(lb_rw_o) && $stable(lb_addr_o) &&
      $stable(transfer_byte_count_o) ##1 $stable(lb_rw_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("direction or address not held after select");

  property p_oe_track;
    @(posedge core_clk_i) disable iff (reset_i)
    !lb_oe_n_o |-> cs_on && lb_rw_o && lb_data_oe_n_o;
  endproperty
  a_oe_track: assert property (p_oe_track)
    else $error("output enable outside a read select");

  property p_oe_with_cs;
    @(posedge core_clk_i) disable iff (reset_i)
    $fell(&lb_cs_n_o) && lb_rw_o |-> !lb_oe_n_o;
  endproperty
  a_oe_with_cs: assert property (p_oe_with_cs)
    else $error("output enable late on read");

  property p_start_pulse;
    @(posedge core_clk_i) disable iff (reset_i)
    !transfer_start_strobe_n_o && tick |-> wide_mode(mode_r) && (&lb_cs_n_o)
      ##1 transfer_start_strobe_n_o && cs_on;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start strobe not one tick ahead of select");

  property p_hi_release;
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(&lb_cs_n_o) |-> lb_addr_hi_oe_n_o;
  endproperty
  a_hi_release: assert property (p_hi_release)
    else $error("upper address pins not released with select");

  property p_turn_gap;
    @(posedge core_clk_i) disable iff (reset_i)
    $fell(lb_data_oe_n_o) && after_read_r |->
      gap_r >= (CNT_W + 1)'(turn_seen_r) + 1'b1;
  endproperty
  a_turn_gap: assert property (p_turn_gap)
    else $error("data driven inside the turnaround after a read");
endmodule : lpb_nonmux

//--- rtl/lpb_tick_div.sv
// divider giving the bus reference tick as a one-cycle enable
// assumes a single core clock; DIV of 1 ticks every cycle
`timescale 1ns/1ps
module lpb_tick_div #(
  parameter int DIV = 1
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_r;

  initial begin
    if (DIV < 1) $error("lpb_tick_div: DIV must be at least 1");
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(DIV - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign tick_o = (cnt_r == CW'(DIV - 1));
endmodule : lpb_tick_div
